// [rtl/dual_adc_map.vh]
`ifndef DUAL_ADC_MAP_VH
`define DUAL_ADC_MAP_VH
// ----------------------------------------
// Special-function register addresses
// ----------------------------------------
`define ADDR_PRIMARY_RESULT_MID   8'hda
`define ADDR_PRIMARY_RESULT_HIGH  8'hdb
`define ADDR_AUX_RESULT_LOW       8'hdc
`define ADDR_AUX_RESULT_HIGH      8'hdd
`define ADDR_AUX_CONV_CONTROL     8'hd2
`define ADDR_PRIMARY_CONTROL      8'hd1
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RESULT_RESET              8'h00
`define AUX_CONTROL_RESET         8'h00
`define PRIMARY_CONTROL_RESET     8'h07
// ----------------------------------------
// Auxiliary control fields
// ----------------------------------------
`define AUX_EXT_REF_BIT           6
`define AUX_CHAN_HI_BIT           5
`define AUX_CHAN_LO_BIT           4
`define AUX_UNIPOLAR_BIT          3
`define AUX_CONTROL_MASK          8'h78
// ----------------------------------------
// Primary control fields
// ----------------------------------------
`define PRIMARY_UNIPOLAR_BIT      5
`define RANGE_MSB                 2
`define RANGE_LSB                 0
`define PRIMARY_CONTROL_MASK      8'h27
`define RANGE_MAX_CODE            3'h6
// ----------------------------------------
// Channel codes, coding offset and range base
// ----------------------------------------
`define CHAN_ANALOG_INPUT_THREE                 2'h0
`define CHAN_ANALOG_INPUT_FOUR                 2'h1
`define CHAN_TEMP                 2'h2
`define CHAN_ANALOG_INPUT_FIVE                 2'h3
`define BIPOLAR_MIDSCALE          16'h8000
`define RANGE_BASE_MV             16'h0014
`endif

// [rtl/result_pair.v]
`timescale 1ns/1ps
`default_nettype none
`include "dual_adc_map.vh"
module result_pair
(
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire        done_i,
	input  wire        unipolar_i,
	input  wire [15:0] raw_i,
	output reg  [15:0] result_o
);
	// Raw code is offset binary from zero; bipolar flips MSB so zero input is midscale
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
			result_o <= {`RESULT_RESET, `RESULT_RESET};
		else if (done_i)
			result_o <= unipolar_i ? raw_i : (raw_i ^ `BIPOLAR_MIDSCALE);
	end
endmodule // result_pair
`default_nettype wire

// [rtl/dual_adc_config_result_regs.v]
// Notes on behaviour
// - Three-bit range code gives 20 mV doubling per step to 1.28 V.
// - Aux reference bit set picks external reference pair, else internal band gap.
// - Aux channel bits pick input three, four, temp sensor, five; minus is ground.
// - Aux unipolar gives 0000H for zero input; bipolar gives 8000H.
// - Temp sensor conversion yields 8000H at zero degrees.
// - One degree rise adds one LSB to aux high byte.
// - Primary result high at DBH, middle at DAH, both reset to zero.
// - Aux result high at DDH, low at DCH, not bit addressable.
// - Primary unipolar gives all-zero for zero input; bipolar gives midscale.
`timescale 1ns/1ps
`default_nettype none
`include "dual_adc_map.vh"
module dual_adc_config_result_regs
(
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire [7:0]  sfr_addr_i,
	input  wire [7:0]  sfr_wdata_i,
	input  wire        sfr_wr_i,
	input  wire        sfr_rd_i,
	output reg  [7:0]  sfr_rdata_o,
	input  wire        primary_done_i,
	input  wire [15:0] primary_raw_i,
	input  wire        aux_done_i,
	input  wire [15:0] aux_raw_i,
	output reg  [15:0] range_mv_o,
	output reg         range_is_volt_o,
	output reg         aux_ext_ref_sel_o,
	output reg         aux_int_ref_sel_o,
	output reg  [3:0]  aux_pos_input_o,
	output reg         aux_neg_is_ground_o,
	output reg         primary_unipolar_o,
	output reg         aux_unipolar_o,
	output reg         temp_cfg_error_o
);
	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	reg  [7:0] aux_ctrl_q;
	reg  [7:0] prim_ctrl_q;
	wire       aux_ctrl_wr;
	wire       prim_ctrl_wr;

	// Result registers have no write path at all, so writes to them are dropped
	assign aux_ctrl_wr  = sfr_wr_i && (sfr_addr_i == `ADDR_AUX_CONV_CONTROL);
	assign prim_ctrl_wr = sfr_wr_i && (sfr_addr_i == `ADDR_PRIMARY_CONTROL);

	// Reserved bits are masked on the way in so they always read back as zero
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
			aux_ctrl_q <= `AUX_CONTROL_RESET;
		else if (aux_ctrl_wr)
			aux_ctrl_q <= sfr_wdata_i & `AUX_CONTROL_MASK;
	end

	always @(posedge clk_i)
	begin
		if (!rst_n_i)
			prim_ctrl_q <= `PRIMARY_CONTROL_RESET;
		else if (prim_ctrl_wr)
			prim_ctrl_q <= sfr_wdata_i & `PRIMARY_CONTROL_MASK;
	end

	wire [2:0] range_code = prim_ctrl_q[`RANGE_MSB:`RANGE_LSB];
	wire [1:0] aux_chan   = {aux_ctrl_q[`AUX_CHAN_HI_BIT], aux_ctrl_q[`AUX_CHAN_LO_BIT]};

	// ----------------------------------------
	// Result pairs
	// ----------------------------------------
	wire [15:0] prim_res;
	wire [15:0] aux_res;

	// Sensor is trimmed upstream so raw 0 = 0 C; bipolar coding puts it at 8000H
	result_pair u_primary
	(
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.done_i     (primary_done_i),
		.unipolar_i (prim_ctrl_q[`PRIMARY_UNIPOLAR_BIT]),
		.raw_i      (primary_raw_i),
		.result_o   (prim_res)
	);

	result_pair u_aux
	(
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.done_i     (aux_done_i),
		.unipolar_i (aux_ctrl_q[`AUX_UNIPOLAR_BIT]),
		.raw_i      (aux_raw_i),
		.result_o   (aux_res)
	);

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	reg [7:0] rdata_d;
	always @*
	begin
		case (sfr_addr_i)
			`ADDR_PRIMARY_RESULT_MID:  rdata_d = prim_res[7:0];
			`ADDR_PRIMARY_RESULT_HIGH: rdata_d = prim_res[15:8];
			`ADDR_AUX_RESULT_LOW:      rdata_d = aux_res[7:0];
			`ADDR_AUX_RESULT_HIGH:     rdata_d = aux_res[15:8];
			`ADDR_AUX_CONV_CONTROL:    rdata_d = aux_ctrl_q;
			`ADDR_PRIMARY_CONTROL:     rdata_d = prim_ctrl_q;
			default:                   rdata_d = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	// Read data is held between reads so the core may pick it up late
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
			sfr_rdata_o <= 8'h00;
		else if (sfr_rd_i)
			sfr_rdata_o <= rdata_d;
	end

	// ----------------------------------------
	// Primary input range
	// ----------------------------------------
	reg [15:0] range_mv_d;
	always @*
	begin
		// Code 7 is undefined; it is clamped to the widest range
		if (range_code > `RANGE_MAX_CODE)
			range_mv_d = `RANGE_BASE_MV << `RANGE_MAX_CODE;
		else
			range_mv_d = `RANGE_BASE_MV << range_code;
	end

	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			range_mv_o      <= `RANGE_BASE_MV;
			range_is_volt_o <= 1'b0;
		end
		else
		begin
			range_mv_o      <= range_mv_d;
			range_is_volt_o <= (range_code >= `RANGE_MAX_CODE);
		end
	end

	// ----------------------------------------
	// Auxiliary reference select
	// ----------------------------------------
	// Both selects come from one bit, so the two references are never picked together
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			aux_ext_ref_sel_o <= 1'b0;
			aux_int_ref_sel_o <= 1'b1;
		end
		else
		begin
			aux_ext_ref_sel_o <= aux_ctrl_q[`AUX_EXT_REF_BIT];
			aux_int_ref_sel_o <= ~aux_ctrl_q[`AUX_EXT_REF_BIT];
		end
	end

	// ----------------------------------------
	// Auxiliary input select
	// ----------------------------------------
	reg [3:0] pos_d;
	always @*
	begin
		case (aux_chan)
			`CHAN_ANALOG_INPUT_THREE: pos_d = 4'h1;
			`CHAN_ANALOG_INPUT_FOUR: pos_d = 4'h2;
			`CHAN_TEMP: pos_d = 4'h4;
			default:    pos_d = 4'h8;
		endcase
	end

	// The negative side has no mux; it stays on ground in every setting
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			aux_pos_input_o     <= 4'h1;
			aux_neg_is_ground_o <= 1'b1;
		end
		else
		begin
			aux_pos_input_o     <= pos_d;
			aux_neg_is_ground_o <= 1'b1;
		end
	end

	// ----------------------------------------
	// Coding select
	// ----------------------------------------
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			primary_unipolar_o <= 1'b0;
			aux_unipolar_o     <= 1'b0;
		end
		else
		begin
			primary_unipolar_o <= prim_ctrl_q[`PRIMARY_UNIPOLAR_BIT];
			aux_unipolar_o     <= aux_ctrl_q[`AUX_UNIPOLAR_BIT];
		end
	end

	// ----------------------------------------
	// Sensor misuse flag
	// ----------------------------------------
	// Flags software misuse of the sensor; it does not override the setting
	wire temp_misuse = (aux_chan == `CHAN_TEMP) &&
	                   (aux_ctrl_q[`AUX_EXT_REF_BIT] || aux_ctrl_q[`AUX_UNIPOLAR_BIT]);

	always @(posedge clk_i)
	begin
		if (!rst_n_i)
			temp_cfg_error_o <= 1'b0;
		else
			temp_cfg_error_o <= temp_misuse;
	end
endmodule // dual_adc_config_result_regs
`default_nettype wire

// [dv/conv_model.sv]
`timescale 1ns/1ps
`default_nettype none
module conv_model
(
	input  wire logic        clk_i,
	input  wire logic [1:0]  go_i,
	input  wire logic [15:0] val_i,
	output var  logic [1:0]  done_o,
	output var  logic [15:0] raw_o
);
	// Raw code is passed through; between conversions it is scrambled so no stale read can pass
	always @(posedge clk_i)
	begin
		done_o <= go_i;
		raw_o <= |go_i ? val_i : ~raw_o;
	end
endmodule // conv_model
`default_nettype wire

// [dv/dual_adc_chk_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module dual_adc_chk
(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic [7:0]  sfr_addr_i,
	input wire logic [7:0]  sfr_wdata_i,
	input wire logic        sfr_wr_i,
	input wire logic        sfr_rd_i,
	input wire logic [7:0]  sfr_rdata_o,
	input wire logic        primary_done_i,
	input wire logic [15:0] primary_raw_i,
	input wire logic        aux_done_i,
	input wire logic [15:0] aux_raw_i,
	input wire logic [15:0] range_mv_o,
	input wire logic        aux_ext_ref_sel_o,
	input wire logic        aux_int_ref_sel_o,
	input wire logic [3:0]  aux_pos_input_o,
	input wire logic        primary_unipolar_o,
	input wire logic        aux_unipolar_o,
	input wire logic        temp_cfg_error_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire cw = sfr_wr_i && sfr_addr_i == 8'hd2;
	AST_REF: assert property (aux_ext_ref_sel_o != aux_int_ref_sel_o) else $error("ref clash");
	AST_XREF: assert property (cw |-> ##2 aux_ext_ref_sel_o == $past(sfr_wdata_i[6], 2)) else $error("ref");
	AST_CHAN: assert property (cw |-> ##2 aux_pos_input_o == 4'h1 << $past(sfr_wdata_i[5:4], 2))
		else $error("chan");
	AST_HOT: assert property ($onehot(aux_pos_input_o)) else $error("onehot");
	AST_RNG: assert property (range_mv_o inside {16'h14, 16'h28, 16'h50, 16'ha0, 16'h140, 16'h280, 16'h500})
		else $error("range");
	AST_TEMP: assert property (cw |-> ##2 temp_cfg_error_o == (aux_pos_input_o[2] &&
		(aux_ext_ref_sel_o || aux_unipolar_o))) else $error("temp");
	AST_AHI: assert property (aux_done_i ##1 (sfr_rd_i && sfr_addr_i == 8'hdd) |=>
		sfr_rdata_o == ($past(aux_raw_i[15:8], 2) ^ {!$past(aux_unipolar_o, 2), 7'h0})) else $error("aux");
	AST_PHI: assert property (primary_done_i ##1 (sfr_rd_i && sfr_addr_i == 8'hdb) |=>
		sfr_rdata_o == ($past(primary_raw_i[15:8], 2) ^ {!$past(primary_unipolar_o, 2), 7'h0})) else $error("pri");
	cover property (aux_done_i ##1 sfr_rd_i);
	cover property (temp_cfg_error_o);
	cover property (range_mv_o == 16'h500);
endmodule // dual_adc_chk
bind dual_adc_config_result_regs dual_adc_chk u_chk (.*);
`default_nettype wire

// [dv/dual_adc_config_result_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module dual_adc_config_result_regs_tb_top;
	logic clk_i = 0, rst_n_i = 0, wr = 0, rd = 0, volt, xr, ir, ng, pu, au, te;
	logic [7:0] addr = 0, wd = 0, rdata;
	logic [1:0] go = 0, done;
	logic [15:0] val = 0, raw, mv;
	logic [3:0] pin;
	int n_errors = 0, checked = 0;
	initial forever #2 clk_i = ~clk_i;
	conv_model u_conv (.clk_i(clk_i), .go_i(go), .val_i(val), .done_o(done), .raw_o(raw));
	dual_adc_config_result_regs u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr), .sfr_wdata_i(wd),
		.sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .primary_done_i(done[0]), .primary_raw_i(raw),
		.aux_done_i(done[1]), .aux_raw_i(raw), .range_mv_o(mv), .range_is_volt_o(volt), .aux_ext_ref_sel_o(xr),
		.aux_int_ref_sel_o(ir), .aux_pos_input_o(pin), .aux_neg_is_ground_o(ng), .primary_unipolar_o(pu),
		.aux_unipolar_o(au), .temp_cfg_error_o(te));
	task chk(input logic [15:0] s, e);
		checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Config outputs settle two edges after the write, so the task waits that out
	task wr8(input logic [7:0] a, d);
		wr = 1; addr = a; wd = d;
		@(negedge clk_i) wr = 0;
		repeat (2) @(negedge clk_i);
	endtask
	// A gap edge after each read keeps the strobe from being lowered and raised in one step
	task rd8(input logic [7:0] a, e);
		rd = 1; addr = a;
		@(negedge clk_i) rd = 0;
		chk(16'(rdata), 16'(e));
		@(negedge clk_i);
	endtask
	task conv(input logic [1:0] g, input logic [15:0] v);
		go = g; val = v;
		@(negedge clk_i) go = 0;
		@(negedge clk_i);
	endtask
	task wrap_up;
		if (n_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#20000 n_errors++;
		wrap_up;
	end
	initial
	begin
		repeat (5) @(negedge clk_i);
		rst_n_i = 1;
		for (int a = 'hda; a <= 'hdd; a++)
			rd8(8'(a), 8'h00);
		wr8(8'hdd, 8'hff);
		rd8(8'hdd, 8'h00);
		for (int c = 0; c < 4; c++)
		begin
			wr8(8'hd2, 8'(c * 16 + (c == 2 ? 8 : 64 * (c % 2))));
			chk(16'(pin), 16'(1 << c));
			chk(16'(xr), 16'(c % 2));
			chk(16'(ir), 16'(1 - c % 2));
			chk(16'(te), 16'(c == 2));
			chk(16'(ng), 16'h1);
			chk(16'(au), 16'(c == 2));
		end
		for (int r = 0; r < 8; r++)
		begin
			wr8(8'hd1, 8'(r));
			chk(mv, 16'(r == 7 ? 1280 : 20 << r));
			chk(16'(volt), 16'(r >= 6));
		end
		wr8(8'hd2, 8'h20);
		conv(2'b10, 16'h0000);
		rd8(8'hdd, 8'h80);
		conv(2'b10, 16'h0100);
		rd8(8'hdd, 8'h81);
		rd8(8'hdc, 8'h00);
		wr8(8'hd2, 8'h08);
		chk(16'(au), 16'h1);
		conv(2'b10, 16'h0000);
		rd8(8'hdd, 8'h00);
		wr8(8'hd1, 8'h20);
		chk(16'(pu), 16'h1);
		conv(2'b01, 16'h0000);
		rd8(8'hdb, 8'h00);
		wr8(8'hd1, 8'h00);
		chk(16'(pu), 16'h0);
		conv(2'b11, 16'h1234);
		rd8(8'hdb, 8'h92);
		rd8(8'hda, 8'h34);
		rd8(8'hdd, 8'h12);
		wrap_up;
	end
endmodule // dual_adc_config_result_regs_tb_top
`default_nettype wire
